// ### rtl/ssr_pkg.sv
// Constants, types and helpers of the segment selector register unit
package ssr_pkg;

  // Segment register encodings; the local table pointer sits after the six
  localparam int         SSR_NSEG    = 7;
  localparam logic [2:0] SSR_SEG_ES  = 3'h0;
  localparam logic [2:0] SSR_SEG_CS  = 3'h1;
  localparam logic [2:0] SSR_SEG_SS  = 3'h2;
  localparam logic [2:0] SSR_SEG_DS  = 3'h3;
  localparam logic [2:0] SSR_SEG_FS  = 3'h4;
  localparam logic [2:0] SSR_SEG_GS  = 3'h5;
  localparam logic [2:0] SSR_SEG_LTP = 3'h6;

  // Selector fields
  localparam int SSR_IDX_MSB  = 15;
  localparam int SSR_IDX_LSB  = 3;
  localparam int SSR_TSEL_BIT = 2;
  localparam int SSR_RP_MSB   = 1;

  // Cached attribute fields
  localparam int SSR_ATTR_W = 4;
  localparam int SSR_ATTR_L = 3;
  localparam int SSR_ATTR_D = 2;

  // Privilege levels
  localparam logic [1:0] SSR_PRIV_KERNEL = 2'h0;
  localparam logic [1:0] SSR_PRIV_USER   = 2'h3;

  // Model-specific addresses of the auxiliary bases
  localparam logic [31:0] SSR_MSR_F_BASE = 32'hc0000100;
  localparam logic [31:0] SSR_MSR_G_BASE = 32'hc0000101;

  // Implemented virtual address width
  localparam int SSR_VA_BITS = 48;

  // Reset values
  localparam logic [15:0]           SSR_SEL_RST   = 16'h0000;
  localparam logic [63:0]           SSR_BASE_RST  = 64'h0000000000000000;
  localparam logic [31:0]           SSR_LIMIT_RST = 32'h0000ffff;
  localparam logic [SSR_ATTR_W-1:0] SSR_ATTR_RST  = 4'h0;
  localparam logic [1:0]            SSR_PRIV_RST  = 2'h0;

  // Kind of memory reference
  typedef enum logic [3:0] {
    SSR_ACC_FETCH  = 4'h1,
    SSR_ACC_DATA   = 4'h2,
    SSR_ACC_STRDST = 4'h4,
    SSR_ACC_STACK  = 4'h8
  } ssr_acc_t;

  // Index zero in the global table
  function automatic logic ssr_is_null(input logic [15:0] sel);
    return sel[SSR_IDX_MSB:SSR_TSEL_BIT] == 14'h0000;
  endfunction

endpackage

// ### rtl/ssr_canon_chk.sv
// Canonical-form check of a virtual address
`timescale 1ns/1ps
module ssr_canon_chk
  import ssr_pkg::*;
(
  // Address under test
  input  wire logic [63:0] i_addr,
  // Result
  output wire logic        o_ok
);

  // Upper bits must all copy the top implemented bit
  assign o_ok = (&i_addr[63:SSR_VA_BITS-1]) | ~(|i_addr[63:SSR_VA_BITS-1]);

endmodule // ssr_canon_chk

// ### rtl/ssr_unit.sv
// Segment selector registers, hidden caches and segment address stage
// Notes on behaviour
// - entry address is table base plus index times eight
// - long mode still scales index by eight
// - table select bit picks global or local base
// - low two selector bits are requester privilege
// - null selector reference faults outside 64-bit mode
// - null loads: code faults, stack conditionally faults
// - feature set: null load clears base, limit, except FS, GS and data registers on privilege-changing return
// - feature clear: null load leaves cache as is
// - six 16-bit selectors, encodings zero to five
// - load copies descriptor into hidden cache
// - code load sets current privilege from descriptor
// - data uses default, strings extra, stack stack
// - 64-bit code base zero, canonical check only
// - 64-bit data and stack bases are zero
// - mode switches leave segment contents untouched
// - auxiliary base added, overflow wraps silently
// - auxiliary overrides checked only for canonical form
// - selector load writes 32-bit auxiliary base
// - privileged model register write loads full base
// - enabled base writes work only 64-bit mode
// - non-canonical auxiliary base write faults
// - compatibility mode ignores upper 32 base bits
// - local table index zero is not null
`timescale 1ns/1ps
module ssr_unit
  import ssr_pkg::*;
(
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // Mode and feature controls
  input  wire logic        i_mode64,
  input  wire logic        i_null_load_zeroes_base_feature,
  input  wire logic        i_user_base_write_enable,
  input  wire logic [63:0] i_global_descriptor_table_base,
  // Entry address lookup
  input  wire logic        i_xlt_valid,
  input  wire logic [15:0] i_xlt_sel,
  output logic             o_xlt_valid,
  output logic [63:0]      o_xlt_addr,
  output logic [1:0]       o_xlt_requester_privilege,
  output logic             o_xlt_null,
  output logic             o_xlt_fault,
  // Selector load with fetched descriptor
  input  wire logic        i_ld_valid,
  input  wire logic [2:0]  i_ld_seg,
  input  wire logic [15:0] i_ld_sel,
  input  wire logic [63:0] i_ld_base,
  input  wire logic [31:0] i_ld_limit,
  input  wire logic [3:0]  i_ld_attr,
  input  wire logic        i_ld_priv_ret,
  output logic             o_ld_done,
  output logic             o_ld_fault,
  // Model register access
  input  wire logic        i_msr_wr,
  input  wire logic        i_msr_rd,
  input  wire logic [31:0] i_msr_addr,
  input  wire logic [63:0] i_msr_data,
  output logic [63:0]      o_msr_rdata,
  // Base-write instructions
  input  wire logic        i_bw_valid,
  input  wire logic        i_bw_g,
  input  wire logic        i_bw_op32,
  input  wire logic [63:0] i_bw_data,
  output logic             o_wr_fault,
  // Address generation
  input  wire logic        i_agu_valid,
  input  ssr_acc_t         i_agu_kind,
  input  wire logic        i_agu_ovr,
  input  wire logic [2:0]  i_agu_ovr_seg,
  input  wire logic [63:0] i_agu_offs,
  output logic             o_agu_valid,
  output logic [63:0]      o_lin_addr,
  output logic             o_agu_fault,
  // Visible state
  input  wire logic [2:0]  i_rd_seg,
  output logic [15:0]      o_rd_sel,
  output logic [63:0]      o_rd_base,
  output logic [1:0]       o_current_privilege,
  output logic             o_code_long,
  output logic             o_code_dsize
);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [15:0]           sel_reg   [SSR_NSEG];
  logic [63:0]           base_reg  [SSR_NSEG];
  logic [31:0]           limit_reg [SSR_NSEG];
  logic [SSR_ATTR_W-1:0] attr_reg  [SSR_NSEG];
  logic [1:0]            cpl_reg;

  // Load decode
  logic        ld_null;
  logic        ld_bad;
  logic        ld_ok;
  logic        ld_clear;
  logic [63:0] ld_base_c;

  assign ld_null = ssr_is_null(i_ld_sel);
  always_comb begin
    ld_bad = 1'b0;
    if (i_ld_seg > SSR_SEG_LTP) begin
      ld_bad = 1'b1;
    end else if (ld_null && i_ld_seg == SSR_SEG_CS) begin
      ld_bad = 1'b1;
    end else if (ld_null && i_ld_seg == SSR_SEG_SS) begin
      ld_bad = !i_mode64 || cpl_reg == SSR_PRIV_USER;
    end
  end
  assign ld_ok = i_ld_valid && !ld_bad;

  // Data registers reloaded by a privilege-changing return keep their fields
  // Auxiliary registers never lose their hidden fields on a null load
  assign ld_clear = i_null_load_zeroes_base_feature &&
                    i_ld_seg != SSR_SEG_FS && i_ld_seg != SSR_SEG_GS &&
                    !(i_ld_priv_ret && i_ld_seg != SSR_SEG_CS &&
                      i_ld_seg != SSR_SEG_SS && i_ld_seg != SSR_SEG_LTP);

  // Segment descriptors carry a 32-bit base; only the table pointer is wide
  assign ld_base_c = (i_ld_seg == SSR_SEG_LTP) ? i_ld_base
                                               : {32'h0, i_ld_base[31:0]};

  // Auxiliary base writes
  logic        msr_hit;
  logic        wr_req;
  logic        wr_perm;
  logic        wr_canon;
  logic        wr_ok;
  logic [2:0]  wr_seg;
  logic [63:0] wr_val;

  assign msr_hit = i_msr_addr == SSR_MSR_F_BASE || i_msr_addr == SSR_MSR_G_BASE;
  assign wr_req  = (i_msr_wr && msr_hit) || i_bw_valid;
  always_comb begin
    if (i_msr_wr) begin
      wr_seg  = (i_msr_addr == SSR_MSR_G_BASE) ? SSR_SEG_GS : SSR_SEG_FS;
      wr_val  = i_msr_data;
      wr_perm = cpl_reg == SSR_PRIV_KERNEL;
    end else begin
      wr_seg  = i_bw_g ? SSR_SEG_GS : SSR_SEG_FS;
      wr_val  = i_bw_op32 ? {32'h0, i_bw_data[31:0]} : i_bw_data;
      wr_perm = i_user_base_write_enable && i_mode64;
    end
  end

  ssr_canon_chk u_wr_canon (
    .i_addr (wr_val),
    .o_ok   (wr_canon)
  );

  assign wr_ok = wr_req && wr_perm && wr_canon;

  // Hidden caches; mode changes never touch them, only loads and base writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int s = 0; s < SSR_NSEG; s++) begin
        sel_reg[s]   <= SSR_SEL_RST;
        base_reg[s]  <= SSR_BASE_RST;
        limit_reg[s] <= SSR_LIMIT_RST;
        attr_reg[s]  <= SSR_ATTR_RST;
      end
    end else begin
      if (ld_ok) begin
        sel_reg[i_ld_seg] <= i_ld_sel;
        if (!ld_null) begin
          base_reg[i_ld_seg]  <= ld_base_c;
          limit_reg[i_ld_seg] <= i_ld_limit;
          attr_reg[i_ld_seg]  <= i_ld_attr;
        end else if (ld_clear) begin
          base_reg[i_ld_seg]  <= SSR_BASE_RST;
          limit_reg[i_ld_seg] <= 32'h0;
        end
        // Otherwise a null load keeps the cache; the null fault hides it
      end
      if (wr_ok) begin
        base_reg[wr_seg] <= wr_val;
      end
    end
  end

  // Current privilege follows each code load
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cpl_reg <= SSR_PRIV_RST;
    end else if (ld_ok && i_ld_seg == SSR_SEG_CS) begin
      cpl_reg <= i_ld_attr[SSR_RP_MSB:0];
    end
  end

  // Load and write answers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ld_done  <= 1'b0;
      o_ld_fault <= 1'b0;
      o_wr_fault <= 1'b0;
    end else begin
      o_ld_done  <= ld_ok;
      o_ld_fault <= i_ld_valid && ld_bad;
      o_wr_fault <= wr_req && !wr_ok;
    end
  end

  // Entry address lookup
  logic        xlt_tsel;
  logic [63:0] xlt_off;
  logic [63:0] xlt_tbl;

  assign xlt_tsel = i_xlt_sel[SSR_TSEL_BIT];
  assign xlt_off  = {48'h0, i_xlt_sel[SSR_IDX_MSB:SSR_IDX_LSB], 3'h0};
  assign xlt_tbl  = xlt_tsel ? base_reg[SSR_SEG_LTP]
                             : i_global_descriptor_table_base;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_xlt_valid               <= 1'b0;
      o_xlt_addr                <= 64'h0;
      o_xlt_requester_privilege <= 2'h0;
      o_xlt_null                <= 1'b0;
      o_xlt_fault               <= 1'b0;
    end else begin
      o_xlt_valid <= i_xlt_valid;
      if (i_xlt_valid) begin
        o_xlt_addr                <= xlt_tbl + xlt_off;
        o_xlt_requester_privilege <= i_xlt_sel[SSR_RP_MSB:0];
        o_xlt_null                <= ssr_is_null(i_xlt_sel);
        // Local table reached while its pointer holds null
        o_xlt_fault <= xlt_tsel && ssr_is_null(sel_reg[SSR_SEG_LTP]);
      end
    end
  end

  // Address generation: segment choice
  logic [2:0]  agu_seg;
  logic [15:0] agu_sel;
  logic [63:0] agu_base;
  logic [31:0] agu_limit;
  logic        agu_aux;
  logic [63:0] agu_lin;
  logic        agu_canon;
  logic        agu_bad;

  always_comb begin
    case (i_agu_kind)
      SSR_ACC_FETCH:  agu_seg = SSR_SEG_CS;
      SSR_ACC_STRDST: agu_seg = SSR_SEG_ES;
      SSR_ACC_STACK:  agu_seg = SSR_SEG_SS;
      default:        agu_seg = i_agu_ovr ? i_agu_ovr_seg : SSR_SEG_DS;
    endcase
  end

  assign agu_sel   = (agu_seg > SSR_SEG_GS) ? SSR_SEL_RST : sel_reg[agu_seg];
  assign agu_base  = (agu_seg > SSR_SEG_GS) ? SSR_BASE_RST : base_reg[agu_seg];
  assign agu_limit = (agu_seg > SSR_SEG_GS) ? 32'h0 : limit_reg[agu_seg];
  assign agu_aux   = agu_seg == SSR_SEG_FS || agu_seg == SSR_SEG_GS;

  always_comb begin
    if (i_mode64) begin
      // Only auxiliary bases count; sum wraps in 64 bits
      agu_lin = agu_aux ? agu_base + i_agu_offs : i_agu_offs;
    end else begin
      agu_lin = {32'h0, agu_base[31:0] + i_agu_offs[31:0]};
    end
  end

  ssr_canon_chk u_agu_canon (
    .i_addr (agu_lin),
    .o_ok   (agu_canon)
  );

  always_comb begin
    if (agu_seg > SSR_SEG_GS) begin
      agu_bad = 1'b1;
    end else if (i_mode64) begin
      agu_bad = !agu_canon;
    end else begin
      agu_bad = ssr_is_null(agu_sel) || i_agu_offs[31:0] > agu_limit;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_agu_valid <= 1'b0;
      o_lin_addr  <= 64'h0;
      o_agu_fault <= 1'b0;
    end else begin
      o_agu_valid <= i_agu_valid;
      o_agu_fault <= i_agu_valid && agu_bad;
      if (i_agu_valid) begin
        o_lin_addr <= agu_lin;
      end
    end
  end

  // Visible state readback
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_rd_sel    <= SSR_SEL_RST;
      o_rd_base   <= SSR_BASE_RST;
      o_msr_rdata <= 64'h0;
    end else begin
      o_rd_sel  <= (i_rd_seg > SSR_SEG_LTP) ? SSR_SEL_RST : sel_reg[i_rd_seg];
      o_rd_base <= (i_rd_seg > SSR_SEG_LTP) ? SSR_BASE_RST : base_reg[i_rd_seg];
      if (i_msr_rd) begin
        if (i_msr_addr == SSR_MSR_F_BASE) begin
          o_msr_rdata <= base_reg[SSR_SEG_FS];
        end else if (i_msr_addr == SSR_MSR_G_BASE) begin
          o_msr_rdata <= base_reg[SSR_SEG_GS];
        end else begin
          o_msr_rdata <= 64'h0;
        end
      end
    end
  end

  assign o_current_privilege = cpl_reg;
  assign o_code_long         = attr_reg[SSR_SEG_CS][SSR_ATTR_L];
  assign o_code_dsize        = attr_reg[SSR_SEG_CS][SSR_ATTR_D];

  // Checks
  property p_cs_null;
    i_ld_valid && i_ld_seg == SSR_SEG_CS && ld_null |=> o_ld_fault && !o_ld_done;
  endproperty
  a_cs_null: assert property (p_cs_null) else $error("null code load not faulted");

  property p_cpl_follow;
    ld_ok && i_ld_seg == SSR_SEG_CS |=> o_current_privilege == $past(i_ld_attr[1:0]);
  endproperty
  a_cpl_follow: assert property (p_cpl_follow) else $error("privilege not taken");

  property p_xlt_gdt;
    i_xlt_valid && !xlt_tsel
      |=> o_xlt_addr == $past(i_global_descriptor_table_base) + $past(xlt_off);
  endproperty
  a_xlt_gdt: assert property (p_xlt_gdt) else $error("entry address wrong");

  property p_null_ref;
    i_agu_valid && !i_mode64 && ssr_is_null(agu_sel) |=> o_agu_fault;
  endproperty
  a_null_ref: assert property (p_null_ref) else $error("null reference not faulted");

  property p_flat_ds;
    i_agu_valid && i_mode64 && agu_seg == SSR_SEG_DS |=> o_lin_addr == $past(i_agu_offs);
  endproperty
  a_flat_ds: assert property (p_flat_ds) else $error("64-bit data base not zero");

  property p_aux_wrap;
    i_agu_valid && i_mode64 && agu_aux
      |=> o_lin_addr == $past(agu_base) + $past(i_agu_offs);
  endproperty
  a_aux_wrap: assert property (p_aux_wrap) else $error("auxiliary sum wrong");

  property p_msr_priv;
    i_msr_wr && msr_hit && cpl_reg != SSR_PRIV_KERNEL |=> o_wr_fault;
  endproperty
  a_msr_priv: assert property (p_msr_priv) else $error("unprivileged base write taken");

  property p_ld_hi_zero;
    ld_ok && i_ld_seg == SSR_SEG_FS && !ld_null && !wr_ok
      |=> base_reg[SSR_SEG_FS][63:32] == 32'h0;
  endproperty
  a_ld_hi_zero: assert property (p_ld_hi_zero) else $error("upper base kept");

  property p_compat_hi;
    i_agu_valid && !i_mode64 |=> o_lin_addr[63:32] == 32'h0;
  endproperty
  a_compat_hi: assert property (p_compat_hi) else $error("upper address bits used");

  property p_bw_mode;
    i_bw_valid && !i_msr_wr && !i_mode64 |=> o_wr_fault;
  endproperty
  a_bw_mode: assert property (p_bw_mode) else $error("base write outside 64-bit mode");

endmodule // ssr_unit

// ### test/ssr_exec_model.sv
// Descriptor source standing in for the execution side
`timescale 1ns/1ps
module ssr_exec_model
  import ssr_pkg::*;
(
  // Selector being loaded
  input  wire logic [15:0] i_sel,
  // Fetched descriptor
  output logic [63:0]      o_base,
  output logic [31:0]      o_limit,
  output logic [3:0]       o_attr
);
  // Upper base bits set so that a 32-bit load shows its truncation
  assign o_base  = {32'h5a5a0000, 16'h0001, i_sel};
  assign o_limit = 32'h00000fff;
  // Long code, privilege taken from the selector
  assign o_attr  = {2'h2, i_sel[1:0]};
endmodule // ssr_exec_model

// ### test/tb_ssr_unit.sv
// Self-checking bench of the segment selector register unit
`timescale 1ns/1ps
module tb_ssr_unit
  import ssr_pkg::*;
();
  logic        clk = 0, rst = 1, m64 = 0, nzb = 1, ube = 1;
  logic [63:0] global_descriptor_table = 64'h0000000000010000;
  logic        xv = 0, xov, xnull, xflt;
  logic [15:0] xs = 16'h0000, lsel = 16'h0000, rsel;
  logic [63:0] xaddr, dbase, md = 64'h0, mrd, bd = 64'h0, aoff = 64'h0, lin, rbase;
  logic [1:0]  xrp, current_privilege;
  logic        lv = 0, lpr = 0, ldone, lflt, mw = 0, mr = 0, bv = 0, bg = 0, b32 = 0;
  logic [2:0]  lseg = 3'h0, aseg = 3'h0, rseg = 3'h0;
  logic [31:0] dlim, ma = 32'h0;
  logic [3:0]  dattr;
  logic        wflt, av = 0, aovr = 0, aov, aflt, clong, cds;
  ssr_acc_t    ak = SSR_ACC_DATA;
  int          fail_count = 0, checks_done = 0, cyc = 0;

  ssr_exec_model i_ssr_exec_model (.i_sel(lsel), .o_base(dbase), .o_limit(dlim), .o_attr(dattr));

  ssr_unit i_ssr_unit (
    .i_clk(clk), .i_rst(rst), .i_mode64(m64), .i_null_load_zeroes_base_feature(nzb),
    .i_user_base_write_enable(ube), .i_global_descriptor_table_base(global_descriptor_table),
    .i_xlt_valid(xv), .i_xlt_sel(xs), .o_xlt_valid(xov), .o_xlt_addr(xaddr),
    .o_xlt_requester_privilege(xrp), .o_xlt_null(xnull), .o_xlt_fault(xflt),
    .i_ld_valid(lv), .i_ld_seg(lseg), .i_ld_sel(lsel), .i_ld_base(dbase), .i_ld_limit(dlim),
    .i_ld_attr(dattr), .i_ld_priv_ret(lpr), .o_ld_done(ldone), .o_ld_fault(lflt),
    .i_msr_wr(mw), .i_msr_rd(mr), .i_msr_addr(ma), .i_msr_data(md), .o_msr_rdata(mrd),
    .i_bw_valid(bv), .i_bw_g(bg), .i_bw_op32(b32), .i_bw_data(bd), .o_wr_fault(wflt),
    .i_agu_valid(av), .i_agu_kind(ak), .i_agu_ovr(aovr), .i_agu_ovr_seg(aseg),
    .i_agu_offs(aoff), .o_agu_valid(aov), .o_lin_addr(lin), .o_agu_fault(aflt),
    .i_rd_seg(rseg), .o_rd_sel(rsel), .o_rd_base(rbase), .o_current_privilege(current_privilege),
    .o_code_long(clong), .o_code_dsize(cds)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  function automatic logic [63:0] eb(input logic [15:0] s);
    return {32'h0, 16'h0001, s};
  endfunction

  task automatic load(input logic [2:0] s, input logic [15:0] v, input logic p, input logic f);
    lv = 1;
    lseg = s;
    lsel = v;
    lpr = p;
    @(negedge clk);
    lv = 0;
    lpr = 0;
    chk("ld_fault", 64'(f), 64'(lflt));
    chk("ld_done", 64'(!f), 64'(ldone));
    @(negedge clk);
  endtask

  task automatic rd(input logic [2:0] s, input logic [15:0] es, input logic [63:0] e);
    rseg = s;
    @(negedge clk);
    @(negedge clk);
    chk("rd_sel", 64'(es), 64'(rsel));
    chk("rd_base", e, rbase);
  endtask

  task automatic xlt(input logic [15:0] s, input logic [63:0] e, input logic n, input logic f);
    xv = 1;
    xs = s;
    @(negedge clk);
    xv = 0;
    chk("xlt_valid", 64'h1, 64'(xov));
    chk("xlt_rp", 64'(s[1:0]), 64'(xrp));
    chk("xlt_null", 64'(n), 64'(xnull));
    chk("xlt_fault", 64'(f), 64'(xflt));
    if (!f) chk("xlt_addr", e, xaddr);
    @(negedge clk);
  endtask

  task automatic mwr(input logic [31:0] a, input logic [63:0] d, input logic f);
    mw = 1;
    ma = a;
    md = d;
    @(negedge clk);
    mw = 0;
    chk("wr_fault", 64'(f), 64'(wflt));
    @(negedge clk);
  endtask

  task automatic mrdc(input logic [31:0] a, input logic [63:0] e);
    mr = 1;
    ma = a;
    @(negedge clk);
    mr = 0;
    chk("msr_rdata", e, mrd);
    @(negedge clk);
  endtask

  task automatic bwr(input logic g, input logic o, input logic [63:0] d, input logic f);
    bv = 1;
    bg = g;
    b32 = o;
    bd = d;
    @(negedge clk);
    bv = 0;
    chk("wr_fault", 64'(f), 64'(wflt));
    @(negedge clk);
  endtask

  task automatic agu(input ssr_acc_t k, input logic o, input logic [2:0] s,
                     input logic [63:0] off, input logic [63:0] e, input logic f);
    av = 1;
    ak = k;
    aovr = o;
    aseg = s;
    aoff = off;
    @(negedge clk);
    av = 0;
    chk("agu_valid", 64'h1, 64'(aov));
    chk("agu_fault", 64'(f), 64'(aflt));
    if (!f) chk("lin_addr", e, lin);
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("Checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    repeat (3) @(negedge clk);
    rst = 0;
    for (int s = 0; s < 6; s++) rd(3'(s), 16'h0, 64'h0);
    chk("cpl", 64'h0, 64'(current_privilege));
    xlt(16'h0004, 64'h0, 0, 1);
    xlt(16'h0000, global_descriptor_table, 1, 0);
    xlt(16'h00fb, global_descriptor_table + 64'h00f8, 0, 0);
    load(SSR_SEG_LTP, 16'h0028, 0, 0);
    xlt(16'h0004, 64'h5a5a000000010028, 0, 0);
    xlt(16'h0016, 64'h5a5a000000010038, 0, 0);
    load(SSR_SEG_CS, 16'h0000, 0, 1);
    load(SSR_SEG_SS, 16'h0000, 0, 1);
    load(3'h7, 16'h0010, 0, 1);
    agu(SSR_ACC_FETCH, 0, 3'h0, 64'h8, 64'h0, 1);
    load(SSR_SEG_DS, 16'h0013, 0, 0);
    rd(SSR_SEG_DS, 16'h0013, eb(16'h0013));
    agu(SSR_ACC_DATA, 0, 3'h0, 64'h100, 64'h00010113, 0);
    agu(SSR_ACC_DATA, 0, 3'h0, 64'h1000, 64'h0, 1);
    agu(SSR_ACC_STACK, 0, 3'h0, 64'h4, 64'h0, 1);
    load(SSR_SEG_ES, 16'h0020, 0, 0);
    agu(SSR_ACC_STRDST, 0, 3'h0, 64'h4, 64'h00010024, 0);
    load(SSR_SEG_CS, 16'h0033, 0, 0);
    rd(SSR_SEG_CS, 16'h0033, eb(16'h0033));
    chk("cpl", 64'h3, 64'(current_privilege));
    chk("code_long", 64'h1, 64'(clong));
    chk("code_dsize", 64'h0, 64'(cds));
    agu(SSR_ACC_FETCH, 0, 3'h0, 64'h8, 64'h0001003b, 0);
    load(SSR_SEG_DS, 16'h0000, 0, 0);
    rd(SSR_SEG_DS, 16'h0000, 64'h0);
    load(SSR_SEG_ES, 16'h0000, 1, 0);
    rd(SSR_SEG_ES, 16'h0000, eb(16'h0020));
    m64 = 1;
    rd(SSR_SEG_CS, 16'h0033, eb(16'h0033));
    load(SSR_SEG_SS, 16'h0000, 0, 1);
    agu(SSR_ACC_DATA, 0, 3'h0, 64'h00007ffffffff000, 64'h00007ffffffff000, 0);
    agu(SSR_ACC_DATA, 0, 3'h0, 64'h0000800000000000, 64'h0, 1);
    agu(SSR_ACC_FETCH, 0, 3'h0, 64'hffff800000000010, 64'hffff800000000010, 0);
    mwr(SSR_MSR_F_BASE, 64'h1000, 1);
    bwr(0, 1, 64'hffffffff12345678, 0);
    rd(SSR_SEG_FS, 16'h0000, 64'h0000000012345678);
    bwr(1, 0, 64'h0000800000000000, 1);
    ube = 0;
    bwr(1, 0, 64'h1000, 1);
    ube = 1;
    load(SSR_SEG_CS, 16'h0008, 0, 0);
    load(SSR_SEG_SS, 16'h0000, 0, 0);
    load(SSR_SEG_FS, 16'h0040, 0, 0);
    rd(SSR_SEG_FS, 16'h0040, eb(16'h0040));
    chk("cpl", 64'h0, 64'(current_privilege));
    mwr(SSR_MSR_F_BASE, 64'hfffffffffffff000, 0);
    mrdc(SSR_MSR_F_BASE, 64'hfffffffffffff000);
    mwr(SSR_MSR_G_BASE, 64'h0001000000000000, 1);
    mwr(32'hc0000102, 64'h0001000000000000, 0);
    agu(SSR_ACC_DATA, 1, SSR_SEG_FS, 64'h2000, 64'h1000, 0);
    agu(SSR_ACC_DATA, 1, SSR_SEG_FS, 64'h0000800000001000, 64'h0, 1);
    m64 = 0;
    agu(SSR_ACC_DATA, 1, SSR_SEG_FS, 64'h10, 64'h00000000fffff010, 0);
    bwr(0, 0, 64'h1000, 1);
    load(SSR_SEG_FS, 16'h0000, 0, 0);
    rd(SSR_SEG_FS, 16'h0000, 64'hfffffffffffff000);
    nzb = 0;
    load(SSR_SEG_DS, 16'h0000, 0, 0);
    agu(SSR_ACC_DATA, 0, 3'h0, 64'h10, 64'h0, 1);
    summarize();
  end
endmodule // tb_ssr_unit
